//--- hdl/sprx_pkg.sv
// constants and types of the s/pdif receiver control and status block
// assumes one 40 MHz clock and a plain address/strobe register port
package sprx_pkg;

    localparam logic [3:0] REG_CONTROL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_CHAN_A = 4'h8;
    localparam logic [3:0] REG_CHAN_B = 4'hc;
    localparam logic [4:0] REG_IRQ_STAT = 5'h10;
    localparam logic [4:0] REG_IRQ_MASK = 5'h14;

    localparam int CTL_ERR_LSB = 0;
    localparam int CTL_LOCK_LSB = 2;
    localparam int CTL_SEL_BIT = 4;
    localparam int CTL_SCDR_BIT = 5;
    localparam int CTL_MUTE_BIT = 6;
    localparam int CTL_EXTPLL_BIT = 7;
    localparam int CTL_SRESET_BIT = 9;
    localparam logic [31:0] CTL_WRITE_MASK = 32'h0000_00ff;
    localparam logic [31:0] CTL_RESET = 32'h0000_0000;

    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_HOLD = 2'h1;
    localparam logic [1:0] ACT_ZERO = 2'h2;
    localparam logic [1:0] ACT_SOFTMUTE = 2'h3;

    // interrupt events: bit0 parity, bit1 coding, bit2 lock lost, bit3 stream lost
    localparam int IRQ_W = 4;

    localparam int SAMPLE_W = 24;
    localparam int CS_BITS = 40;
    // soft mute ramp: one attenuation step (shift by one) every step time
    localparam int MUTE_STEP_NS = 1000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int MUTE_STEP_CYC = (MUTE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic parityErr;
        logic codingErr;
        logic validA;
        logic validB;
        logic nonAudioA;
        logic nonAudioB;
        logic nonAudioFrame;
        logic csBitA;
        logic csBitB;
        logic blockStart;
    } sprx_flags_type;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic write;
        logic read;
    } sprx_bus_type;

endpackage : sprx_pkg

//--- hdl/sprx_sync.sv
// two flip-flop synchroniser for one level
// assumes the input is asynchronous to clk
`timescale 1ns/10ps
`default_nettype none
module sprx_sync (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // level in and out
    input wire logic din,
    output logic dout
);
    logic stage1Reg;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            stage1Reg <= 1'b0;
            dout <= 1'b0;
        end else begin
            stage1Reg <= din;
            dout <= stage1Reg;
        end
    end
endmodule : sprx_sync
`default_nettype wire

//--- hdl/sprx_cs_capture.sv
// captures 40 channel status bits of one channel, one bit per subframe
// assumes one sample strobe per subframe and a block start marker
`timescale 1ns/10ps
`default_nettype none
module sprx_cs_capture #(
    parameter int BITS = 40
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // receiver side
    input wire logic sampleStb,
    input wire logic blockStart,
    input wire logic csBit,
    // captured bytes, byte 0 lowest
    output logic [BITS-1:0] csBytes
);
    logic [BITS-1:0] shiftReg;
    logic [7:0] countReg;

    // bits arrive lsb first; full set copied out when the 40th lands
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            shiftReg <= '0;
            countReg <= 8'h00;
            csBytes <= '0;
        end else if (sampleStb) begin
            if (blockStart) begin
                shiftReg <= {csBit, shiftReg[BITS-1:1]};
                countReg <= 8'h01;
            end else if (countReg != 8'h00 && countReg < 8'(BITS)) begin
                shiftReg <= {csBit, shiftReg[BITS-1:1]};
                countReg <= countReg + 8'h01;
                if (countReg == 8'(BITS - 1)) begin
                    csBytes <= {csBit, shiftReg[BITS-1:1]};
                end
            end
        end
    end
endmodule : sprx_cs_capture
`default_nettype wire

//--- hdl/sprx_control_status.sv
// control, status and sample conditioning of the s/pdif receiver
// assumes the decoder front end delivers samples on clk with per-subframe flags
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module sprx_control_status
    import sprx_pkg::*;
#(
    parameter int SW = SAMPLE_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire logic [4:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    // decoder front end, same clock
    input wire logic sampleStbA,
    input wire logic sampleStbB,
    input wire logic [SW-1:0] sampleIn,
    input wire sprx_pkg::sprx_flags_type flagsIn,
    // asynchronous pll state pins
    input wire logic pllLockPin,
    input wire logic extLockPin,
    input wire logic streamLostPin,
    // conditioned output
    output logic [SW-1:0] leftOut,
    output logic [SW-1:0] rightOut,
    output logic outStb,
    output logic singleChanDoubleRate,
    output logic externalPllSelect,
    output logic softResetPulse,
    output logic irq
);
    import sprx_pkg::*;

    logic [31:0] controlReg;
    logic softResetReg;
    logic [1:0] stickyErrReg;
    logic [IRQ_W-1:0] irqStatReg, irqMaskReg;
    logic pllLockSync, extLockSync, streamLostSync;
    logic locked, lockedDlyReg, streamLostDlyReg;
    logic [SW-1:0] lastGoodA, lastGoodB;
    logic [SW-1:0] outAReg, outBReg;
    logic [4:0] muteShiftReg;
    logic [15:0] muteCntReg;
    logic validAReg, validBReg, naAReg, naBReg, naFrameReg;
    logic [CS_BITS-1:0] csA, csB;
    logic rxReset_n;
    logic [1:0] errAct, lockAct;
    logic badSample, lockBad, softMuting, anyStb;
    logic [IRQ_W-1:0] irqEvents;
    logic [SW-1:0] chosen;
    logic isA;
    logic statusRead;

    // receiver logic reset: hard reset or soft reset; pll pins keep running
    assign rxReset_n = reset_n && !softResetReg;

    sprx_sync syncPll (.clk(clk), .reset_n(reset_n), .din(pllLockPin), .dout(pllLockSync));
    sprx_sync syncExt (.clk(clk), .reset_n(reset_n), .din(extLockPin), .dout(extLockSync));
    sprx_sync syncLost (.clk(clk), .reset_n(reset_n), .din(streamLostPin), .dout(streamLostSync));

    assign externalPllSelect = controlReg[CTL_EXTPLL_BIT];
    assign locked = externalPllSelect ? extLockSync : pllLockSync;
    assign singleChanDoubleRate = controlReg[CTL_SCDR_BIT];
    assign softResetPulse = softResetReg;
    assign errAct = controlReg[CTL_ERR_LSB +: 2];
    assign lockAct = controlReg[CTL_LOCK_LSB +: 2];

    // control register; bit 9 self-clears
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            controlReg <= CTL_RESET;
            softResetReg <= 1'b0;
        end else begin
            softResetReg <= 1'b0;
            if (regWrite && regAddr == {1'b0, REG_CONTROL}) begin
                controlReg <= regWdata & CTL_WRITE_MASK;
                softResetReg <= regWdata[CTL_SRESET_BIT];
            end
        end
    end

    // mode flags, refreshed per subframe
    always_ff @(posedge clk) begin
        if (!rxReset_n) begin
            validAReg <= 1'b0;
            validBReg <= 1'b0;
            naAReg <= 1'b0;
            naBReg <= 1'b0;
            naFrameReg <= 1'b0;
        end else begin
            if (sampleStbA) begin
                validAReg <= flagsIn.validA;
                naAReg <= flagsIn.nonAudioA;
                naFrameReg <= flagsIn.nonAudioFrame;
            end
            if (sampleStbB) begin
                validBReg <= flagsIn.validB;
                naBReg <= flagsIn.nonAudioB;
            end
        end
    end

    assign anyStb = sampleStbA || sampleStbB;
    assign isA = sampleStbA;
    assign badSample = anyStb && (flagsIn.parityErr || flagsIn.codingErr);
    assign lockBad = !locked || streamLostSync;
    // soft mute only for linear pcm; non-linear falls back to zeros
    assign softMuting = lockBad && lockAct == ACT_SOFTMUTE && !(validAReg || validBReg);
    assign statusRead = regRead && regAddr == {1'b0, REG_STATUS};

    // sticky errors: set beats clear-on-read
    always_ff @(posedge clk) begin
        if (!rxReset_n) begin
            stickyErrReg <= 2'h0;
        end else begin
            stickyErrReg <= statusRead ? 2'h0 : stickyErrReg;
            if (anyStb && flagsIn.parityErr) begin
                stickyErrReg[0] <= 1'b1;
            end
            if (anyStb && flagsIn.codingErr) begin
                stickyErrReg[1] <= 1'b1;
            end
        end
    end

    // soft mute ramp, one halving per step
    always_ff @(posedge clk) begin
        if (!rxReset_n) begin
            muteShiftReg <= 5'h00;
            muteCntReg <= 16'h0000;
        end else if (!softMuting) begin
            muteShiftReg <= 5'h00;
            muteCntReg <= 16'h0000;
        end else if (muteCntReg == 16'(MUTE_STEP_CYC - 1)) begin
            muteCntReg <= 16'h0000;
            if (muteShiftReg != 5'(SW)) begin
                muteShiftReg <= muteShiftReg + 5'h01;
            end
        end else begin
            muteCntReg <= muteCntReg + 16'h0001;
        end
    end

    // sample conditioning by error and lock action
    always_comb begin
        chosen = sampleIn;
        if (badSample) begin
            case (errAct)
                ACT_HOLD: chosen = isA ? lastGoodA : lastGoodB;
                ACT_ZERO: chosen = '0;
                default: chosen = sampleIn;
            endcase
        end
        if (lockBad) begin
            case (lockAct)
                ACT_HOLD: chosen = isA ? lastGoodA : lastGoodB;
                ACT_ZERO: chosen = '0;
                ACT_SOFTMUTE: begin
                    if (softMuting) begin
                        chosen = SW'($signed(isA ? lastGoodA : lastGoodB) >>> muteShiftReg);
                    end else begin
                        chosen = '0;
                    end
                end
                default: chosen = sampleIn;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rxReset_n) begin
            lastGoodA <= '0;
            lastGoodB <= '0;
        end else if (anyStb && !badSample && !lockBad) begin
            if (isA) begin
                lastGoodA <= sampleIn;
            end else begin
                lastGoodB <= sampleIn;
            end
        end
    end

    // output samples; in single channel mode the chosen side feeds both slots
    always_ff @(posedge clk) begin
        if (!rxReset_n) begin
            outAReg <= '0;
            outBReg <= '0;
            outStb <= 1'b0;
        end else begin
            outStb <= anyStb;
            if (anyStb) begin
                if (singleChanDoubleRate) begin
                    if (isA != controlReg[CTL_SEL_BIT]) begin
                        outAReg <= chosen;
                        outBReg <= chosen;
                    end
                end else if (isA) begin
                    outAReg <= chosen;
                end else begin
                    outBReg <= chosen;
                end
            end
        end
    end

    // mute forces silence on data only; the strobe keeps running
    assign leftOut = controlReg[CTL_MUTE_BIT] ? '0 : outAReg;
    assign rightOut = controlReg[CTL_MUTE_BIT] ? '0 : outBReg;

    sprx_cs_capture #(.BITS(CS_BITS)) capA (.clk(clk), .reset_n(rxReset_n), .sampleStb(sampleStbA),
        .blockStart(flagsIn.blockStart), .csBit(flagsIn.csBitA), .csBytes(csA));
    sprx_cs_capture #(.BITS(CS_BITS)) capB (.clk(clk), .reset_n(rxReset_n), .sampleStb(sampleStbB),
        .blockStart(flagsIn.blockStart), .csBit(flagsIn.csBitB), .csBytes(csB));

    // interrupt events: parity, coding, lock lost, stream lost edges
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lockedDlyReg <= 1'b0;
            streamLostDlyReg <= 1'b0;
        end else begin
            lockedDlyReg <= locked;
            streamLostDlyReg <= streamLostSync;
        end
    end
    assign irqEvents = {streamLostSync && !streamLostDlyReg, lockedDlyReg && !locked,
        anyStb && flagsIn.codingErr, anyStb && flagsIn.parityErr};

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irqStatReg <= '0;
            irqMaskReg <= '0;
        end else begin
            if (regWrite && regAddr == REG_IRQ_STAT) begin
                irqStatReg <= (irqStatReg & ~regWdata[IRQ_W-1:0]) | irqEvents;
            end else begin
                irqStatReg <= irqStatReg | irqEvents;
            end
            if (regWrite && regAddr == REG_IRQ_MASK) begin
                irqMaskReg <= regWdata[IRQ_W-1:0];
            end
        end
    end
    assign irq = |(irqStatReg & irqMaskReg);

    // read port, data in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            regRdata <= 32'h0000_0000;
        end else if (regRead) begin
            case (regAddr)
                {1'b0, REG_CONTROL}: regRdata <= controlReg;
                {1'b0, REG_STATUS}: regRdata <= {csB[7:0], csA[7:0], 8'h00, stickyErrReg[1],
                    stickyErrReg[0], streamLostSync, locked, validAReg || validBReg,
                    naFrameReg, naBReg, naAReg};
                {1'b0, REG_CHAN_A}: regRdata <= csA[39:8];
                {1'b0, REG_CHAN_B}: regRdata <= csB[39:8];
                REG_IRQ_STAT: regRdata <= {{(32-IRQ_W){1'b0}}, irqStatReg};
                REG_IRQ_MASK: regRdata <= {{(32-IRQ_W){1'b0}}, irqMaskReg};
                default: regRdata <= 32'h0000_0000;
            endcase
        end else begin
            regRdata <= 32'h0000_0000;
        end
    end

    a_sticky_read_race: assert property (@(posedge clk) disable iff (!rxReset_n)
        (statusRead && anyStb && flagsIn.parityErr) |=> stickyErrReg[0])
        else $error("parity error lost on status read");
    a_sticky_hold: assert property (@(posedge clk) disable iff (!rxReset_n)
        (stickyErrReg[1] && !statusRead) |=> stickyErrReg[1])
        else $error("coding error bit dropped without read");
    a_mute_output: assert property (@(posedge clk) disable iff (!rxReset_n)
        (controlReg[CTL_MUTE_BIT] && anyStb)
        |=> outStb && (!controlReg[CTL_MUTE_BIT] || (leftOut == '0 && rightOut == '0)))
        else $error("muted output not silent");
    a_zero_on_error: assert property (@(posedge clk) disable iff (!rxReset_n)
        (sampleStbA && badSample && errAct == ACT_ZERO && !lockBad && !singleChanDoubleRate)
        |=> outAReg == '0)
        else $error("bad sample not zeroed");
    a_hold_on_unlock: assert property (@(posedge clk) disable iff (!rxReset_n)
        (sampleStbA && !locked && lockAct == ACT_HOLD && !singleChanDoubleRate)
        |=> outAReg == $past(lastGoodA))
        else $error("last sample not held on unlock");
    a_nonlinear_zero: assert property (@(posedge clk) disable iff (!rxReset_n)
        (sampleStbA && lockBad && lockAct == ACT_SOFTMUTE && validAReg && !singleChanDoubleRate)
        |=> outAReg == '0)
        else $error("non-linear data not zeroed");
    a_soft_reset_clear: assert property (@(posedge clk) disable iff (!reset_n)
        (regWrite && regAddr == {1'b0, REG_CONTROL} && regWdata[CTL_SRESET_BIT])
        |=> ##1 stickyErrReg == 2'h0)
        else $error("soft reset left errors set");
    a_status_lock: assert property (@(posedge clk) disable iff (!reset_n)
        statusRead |=> regRdata[4] == $past(locked))
        else $error("lock bit wrong in status");
    // readout mapping, error capture and datapath checks
    a_status_stream: assert property (@(posedge clk) disable iff (!reset_n)
        statusRead |=> regRdata[5] == $past(streamLostSync))
        else $error("stream bit wrong");
    a_status_valid: assert property (@(posedge clk) disable iff (!reset_n)
        statusRead |=> regRdata[3] == $past(validAReg || validBReg))
        else $error("validity bit wrong");
    a_status_nonaudio: assert property (@(posedge clk) disable iff (!reset_n)
        statusRead |=> regRdata[2:0] == $past({naFrameReg, naBReg, naAReg}))
        else $error("non-audio bits wrong");
    a_status_errors: assert property (@(posedge clk) disable iff (!reset_n)
        statusRead |=> regRdata[7:6] == $past(stickyErrReg))
        else $error("error bits wrong");
    a_status_byte0: assert property (@(posedge clk) disable iff (!reset_n)
        statusRead |=> regRdata[31:16] == $past({csB[7:0], csA[7:0]}))
        else $error("byte0 pair wrong");
    a_chan_a_bytes: assert property (@(posedge clk) disable iff (!reset_n)
        (regRead && regAddr == {1'b0, REG_CHAN_A}) |=> regRdata == $past(csA[39:8]))
        else $error("chan a bytes wrong");
    a_parity_sets: assert property (@(posedge clk) disable iff (!rxReset_n)
        (anyStb && flagsIn.parityErr) |=> stickyErrReg[0])
        else $error("parity error not kept");
    a_coding_sets: assert property (@(posedge clk) disable iff (!rxReset_n)
        (anyStb && flagsIn.codingErr) |=> stickyErrReg[1])
        else $error("coding error not kept");
    a_read_clears: assert property (@(posedge clk) disable iff (!rxReset_n)
        (statusRead && !(anyStb && (flagsIn.parityErr || flagsIn.codingErr))) |=> stickyErrReg == 2'h0)
        else $error("errors not cleared by read");
    a_single_chan_skip: assert property (@(posedge clk) disable iff (!rxReset_n)
        (singleChanDoubleRate && anyStb && isA == controlReg[CTL_SEL_BIT]) |=> $stable(outAReg) && $stable(outBReg))
        else $error("unselected channel used");
    a_single_chan_copy: assert property (@(posedge clk) disable iff (!rxReset_n)
        (singleChanDoubleRate && anyStb && isA != controlReg[CTL_SEL_BIT]) |=> outAReg == outBReg)
        else $error("selected channel not copied");
    a_two_chan_split: assert property (@(posedge clk) disable iff (!rxReset_n)
        (!singleChanDoubleRate && sampleStbB) |=> $stable(outAReg))
        else $error("b sample reached left");
    a_zero_on_unlock: assert property (@(posedge clk) disable iff (!rxReset_n)
        (sampleStbA && lockBad && lockAct == ACT_ZERO && !singleChanDoubleRate) |=> outAReg == '0)
        else $error("unlock not zeroed");
    a_hold_on_error: assert property (@(posedge clk) disable iff (!rxReset_n)
        (sampleStbA && badSample && errAct == ACT_HOLD && !lockBad && !singleChanDoubleRate)
        |=> outAReg == $past(lastGoodA))
        else $error("bad sample not held");
    a_mute_step: assert property (@(posedge clk) disable iff (!rxReset_n)
        (softMuting && muteCntReg == 16'(MUTE_STEP_CYC - 1) && muteShiftReg != 5'(SW))
        |=> muteShiftReg == $past(muteShiftReg) + 5'h01)
        else $error("mute ramp stalled");
    a_irq_set_wins: assert property (@(posedge clk) disable iff (!reset_n)
        irqEvents[0] |=> irqStatReg[0])
        else $error("interrupt event lost");
endmodule : sprx_control_status
`default_nettype wire

//--- tb/sprx_frontend_model.sv
// decoder front end model: subframe strobes, flags and pll pins
// assumes the block under test samples everything on the same clk
`timescale 1ns/10ps
`default_nettype none
module sprx_frontend_model (
    // clock
    input wire logic clk,
    // decoded subframes
    output logic stbA,
    output logic stbB,
    output logic [23:0] sample,
    output sprx_pkg::sprx_flags_type flags,
    // pll state pins
    output logic pllLock,
    output logic extLock,
    output logic streamLost
);
    import sprx_pkg::*;

    initial begin
        stbA = 1'b0;
        stbB = 1'b0;
        sample = '0;
        flags = '0;
        pllLock = 1'b0;
        extLock = 1'b0;
        streamLost = 1'b0;
    end

    // one subframe; data and flags turn to junk once the strobe drops
    task automatic send(input logic b, input logic [23:0] d, input sprx_flags_type f);
        @(posedge clk);
        stbA <= !b;
        stbB <= b;
        sample <= d;
        flags <= f;
        @(posedge clk);
        stbA <= 1'b0;
        stbB <= 1'b0;
        sample <= ~d;
        flags <= ~f;
    endtask : send

    task automatic pins(input logic l, input logic e, input logic s);
        @(posedge clk);
        pllLock <= l;
        extLock <= e;
        streamLost <= s;
    endtask : pins
endmodule : sprx_frontend_model
`default_nettype wire

//--- tb/sprx_control_status_tb.sv
// self-checking bench of the receiver control and status block
// assumes the front end model shares clk; pins settle within 4 cycles
`timescale 1ns/10ps
`default_nettype none
module sprx_control_status_tb;
    import sprx_pkg::*;
    localparam logic [9:0] F_PAR = 10'h200, F_COD = 10'h100, F_VA = 10'h080;
    localparam logic [9:0] F_NA = 10'h020, F_NB = 10'h010, F_NF = 10'h008;
    localparam logic [9:0] F_CSA = 10'h004, F_CSB = 10'h002, F_BLK = 10'h001;
    localparam logic [39:0] CS_A = 40'h44332211a5, CS_B = 40'h887766555a;
    logic clk, reset_n, regWrite, regRead, stbA, stbB, pllLock, extLock, streamLost;
    logic [4:0] regAddr;
    logic [31:0] regWdata, regRdata, tmp, code;
    logic [23:0] sample, leftOut, rightOut;
    logic outStb, scdr, extSel, srPulse, irq;
    sprx_flags_type flags;
    int n_errors, samples_checked;

    sprx_control_status #(.SW(24)) sprx_control_status_inst (
        .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .sampleStbA(stbA), .sampleStbB(stbB), .sampleIn(sample), .flagsIn(flags),
        .pllLockPin(pllLock), .extLockPin(extLock), .streamLostPin(streamLost),
        .leftOut(leftOut), .rightOut(rightOut), .outStb(outStb),
        .singleChanDoubleRate(scdr), .externalPllSelect(extSel),
        .softResetPulse(srPulse), .irq(irq)
    );

    sprx_frontend_model fe (
        .clk(clk), .stbA(stbA), .stbB(stbB), .sample(sample), .flags(flags),
        .pllLock(pllLock), .extLock(extLock), .streamLost(streamLost)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic conclude;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
        samples_checked++;
        if (got !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", what, e, got);
            n_errors++;
        end
    endtask : chk

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        d = regRdata;
    endtask : rd

    task automatic rchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e, input string what);
        logic [31:0] v;
        rd(a, v);
        chk(what, e, v & m);
    endtask : rchk

    task automatic xfer(input logic b, input logic [23:0] d, input logic [9:0] f, input logic [23:0] e);
        fe.send(b, d, f);
        #1;
        chk("output strobe", 32'h1, {31'h0, outStb});
        chk("sample out", {8'h0, e}, {8'h0, (b ? rightOut : leftOut)});
    endtask : xfer

    task automatic settle;
        repeat (4) @(posedge clk);
    endtask : settle

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        conclude();
    end

    initial begin
        n_errors = 0;
        samples_checked = 0;
        regAddr = '0;
        regWdata = '0;
        regWrite = 1'b0;
        regRead = 1'b0;
        reset_n = 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        rchk(5'h00, 32'hffffffff, 32'h0, "control at reset");
        rchk(5'h04, 32'hffffffff, 32'h0, "status at reset");
        wr(5'h00, 32'hfffffdff);
        rchk(5'h00, 32'hffffffff, 32'h000000ff, "control readback");
        chk("mode pins", 32'h3, {30'h0, scdr, extSel});
        wr(5'h00, 32'h0);
        fe.pins(1'b1, 1'b0, 1'b0);
        settle();
        rchk(5'h04, 32'h30, 32'h10, "lock flag");
        wr(5'h00, 32'h80);
        settle();
        rchk(5'h04, 32'h10, 32'h0, "external lock");
        wr(5'h00, 32'h0);
        fe.pins(1'b1, 1'b0, 1'b1);
        settle();
        rchk(5'h04, 32'h20, 32'h20, "stream lost");
        fe.pins(1'b1, 1'b0, 1'b0);
        settle();
        fe.send(1'b0, 24'h0, F_VA | F_NA | F_NF);
        fe.send(1'b1, 24'h0, F_NB | F_NF);
        rchk(5'h04, 32'h0f, 32'h0f, "audio flags");
        fe.send(1'b0, 24'h0, 10'h0);
        fe.send(1'b1, 24'h0, 10'h0);
        rchk(5'h04, 32'h0f, 32'h0, "audio flags idle");
        fe.send(1'b0, 24'h0, F_PAR);
        rchk(5'h04, 32'hc0, 32'h40, "parity sticky");
        rchk(5'h04, 32'hc0, 32'h0, "parity cleared");
        fe.send(1'b1, 24'h0, F_COD);
        settle();
        rchk(5'h04, 32'hc0, 32'h80, "coding sticky");
        rchk(5'h04, 32'hc0, 32'h0, "coding cleared");
        // error lands in the very cycle of the read
        fork
            fe.send(1'b1, 24'h0, F_PAR);
            rd(5'h04, tmp);
        join
        rchk(5'h04, 32'h40, 32'h40, "error during read");
        rchk(5'h10, 32'h0f, 32'h0f, "event latch");
        wr(5'h14, 32'h1);
        @(posedge clk);
        #1;
        chk("irq on", 32'h1, {31'h0, irq});
        wr(5'h10, 32'h1);
        @(posedge clk);
        #1;
        chk("irq cleared", 32'h0, {31'h0, irq});
        fe.send(1'b0, 24'h0, F_PAR);
        @(posedge clk);
        #1;
        chk("irq again", 32'h1, {31'h0, irq});
        wr(5'h14, 32'h0);
        @(posedge clk);
        #1;
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(5'h10, 32'hf);
        rchk(5'h10, 32'hf, 32'h0, "event clear");
        rchk(5'h18, 32'hffffffff, 32'h0, "unmapped read");
        rd(5'h04, tmp);
        // k 0..3 sweep the sample error field, 4..6 the lock error field
        for (int k = 0; k < 7; k++) begin
            code = (k < 4) ? k : k - 4;
            wr(5'h00, (k < 4) ? code : code << 2);
            xfer(1'b0, 24'h100000 + k, 10'h0, 24'h100000 + k);
            if (k >= 4) begin
                fe.pins(1'b0, 1'b0, 1'b0);
                settle();
            end
            xfer(1'b0, 24'h0abcde, (k < 4) ? F_PAR : 10'h0,
                 (code == 1) ? 24'h100000 + k : (code == 2) ? 24'h0 : 24'h0abcde);
            fe.pins(1'b1, 1'b0, 1'b0);
            settle();
        end
        wr(5'h00, 32'hc);
        xfer(1'b0, 24'h400000, 10'h0, 24'h400000);
        fe.pins(1'b1, 1'b0, 1'b1);
        settle();
        fe.send(1'b0, 24'h0abcde, 10'h0);
        #1;
        chk("mute ramp start", 32'h1, {31'h0, (leftOut <= 24'h400000 && leftOut !== 24'h0)});
        repeat (1000) @(posedge clk);
        fe.send(1'b0, 24'h0abcde, 10'h0);
        #1;
        chk("mute ramp end", 32'h0, {8'h0, leftOut});
        fe.pins(1'b1, 1'b0, 1'b0);
        settle();
        xfer(1'b0, 24'h300000, F_VA, 24'h300000);
        fe.pins(1'b1, 1'b0, 1'b1);
        settle();
        xfer(1'b0, 24'h0abcde, F_VA, 24'h0);
        fe.pins(1'b1, 1'b0, 1'b0);
        settle();
        // mute drops data only; strobes keep coming
        wr(5'h00, 32'h40);
        xfer(1'b0, 24'h123456, 10'h0, 24'h0);
        wr(5'h00, 32'h0);
        @(posedge clk);
        #1;
        chk("mute released", 32'h123456, {8'h0, leftOut});
        wr(5'h00, 32'h20);
        xfer(1'b0, 24'h0aaaaa, 10'h0, 24'h0aaaaa);
        xfer(1'b1, 24'h0bbbbb, 10'h0, 24'h0aaaaa);
        wr(5'h00, 32'h30);
        xfer(1'b1, 24'h0ccccc, 10'h0, 24'h0ccccc);
        chk("single chan left", 32'h0ccccc, {8'h0, leftOut});
        wr(5'h00, 32'h0);
        fe.send(1'b0, 24'h055555, F_PAR);
        wr(5'h00, 32'h201);
        #1;
        tmp = {31'h0, srPulse};
        repeat (2) begin
            @(posedge clk);
            #1;
            tmp[0] = tmp[0] | srPulse;
        end
        chk("soft reset pulse", 32'h1, tmp);
        chk("left after soft reset", 32'h0, {8'h0, leftOut});
        rchk(5'h04, 32'hd0, 32'h10, "status after soft reset");
        rchk(5'h00, 32'hffffffff, 32'h1, "control kept");
        for (int i = 0; i < 40; i++) begin
            fe.send(1'b0, 24'h0, (CS_A[i] ? F_CSA : 10'h0) | ((i == 0) ? F_BLK : 10'h0));
            fe.send(1'b1, 24'h0, (CS_B[i] ? F_CSB : 10'h0) | ((i == 0) ? F_BLK : 10'h0));
        end
        settle();
        rchk(5'h04, 32'hffff0000, {CS_B[7:0], CS_A[7:0], 16'h0}, "byte0 pair");
        rchk(5'h08, 32'hffffffff, CS_A[39:8], "chan a bytes");
        rchk(5'h0c, 32'hffffffff, CS_B[39:8], "chan b bytes");
        conclude();
    end
endmodule : sprx_control_status_tb
`default_nettype wire
